// *** rtl/mtu_defs.vh ***
`ifndef MTU_DEFS_VH
`define MTU_DEFS_VH

// ****************************************************
// register indices, byte address is four times these
// ****************************************************
`define MTU_IDX_FIRST_COUNTER   8'h40
`define MTU_IDX_FIRST_RELOAD    8'h42
`define MTU_IDX_SECOND_RELOAD   8'h44
`define MTU_IDX_SECOND_COUNTER  8'h46
`define MTU_IDX_PRESCALE        8'h48
`define MTU_IDX_CLOCK_CTRL      8'h4A
`define MTU_IDX_MODE_CTRL       8'h4C
`define MTU_IDX_INT_CTRL        8'h4E
`define MTU_IDX_INT_CLEAR       8'h50

// ****************************************************
// field positions
// ****************************************************
`define MTU_CLK1_LSB            0
`define MTU_CLK1_MSB            2
`define MTU_CLK2_LSB            3
`define MTU_CLK2_MSB            5
`define MTU_MODE_LSB            0
`define MTU_MODE_MSB            1
`define MTU_EDGE_BIT            2
`define MTU_PINEN_BIT           4
`define MTU_INIT_BIT            6
`define MTU_PEND_LSB            0
`define MTU_PEND_MSB            3
`define MTU_IEN_LSB             4
`define MTU_IEN_MSB             7
`define MTU_SRC_A               0
`define MTU_SRC_B               1
`define MTU_SRC_C               2
`define MTU_SRC_D               3

// ****************************************************
// encodings and reset values
// ****************************************************
`define MTU_MODE_PWM            2'b00
`define MTU_MODE_CAPTURE        2'b01
`define MTU_MODE_DUAL           2'b10
`define MTU_CSEL_STOP           3'b000
`define MTU_CSEL_PRESCALED      3'b001
`define MTU_CSEL_SLOW           3'b100
`define MTU_CNT_PRESET          16'hFFFF
`define MTU_CNT_ZERO            16'h0000
`define MTU_PS_ZERO             5'h00
`define MTU_BYTE_ZERO           8'h00
`define MTU_NIB_ZERO            4'h0
`define MTU_WORD_ZERO           32'h0000_0000

`endif

// *** rtl/mtu_timer.v ***
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// - two 16-bit down-counters with reload registers
// - per-counter clock select: stop, prescaled, slow
// - 5-bit prescaler divides by divisor plus one
// - reset clears divisor and prescaler counter
// - slow clock synchronized before use
// - counters hold while system clock stops
// - counters disabled after reset until configured
// - pwm mode reloads alternately first, second
// - pwm restart always reloads first register first
// - pwm toggles pin on every underflow
// - pwm reload sets pending a or b
// - second counter underflow raises source d
// - capture edge copies first counter to register
// - preset on capture forces counter to ffff
// - capture sets a on edge, c on underflow
// - dual mode reload from first, optional toggle
// - dual mode rising toggle sets c, a-enabled
// - dual mode second counter reloads, sets d
// - a, b, c form irq one; d irq two
// - mode field 00 pwm, 01 capture, 10 dual
// - clock codes 000 stop, 001 prescaled, 100 slow
// - edge bit 0 falling, 1 rising
// - pin starts at software initial level
`include "mtu_defs.vh"

module mtu_timer #(
  parameter CNT_W = 16,
  parameter PS_W  = 5
) (
  input  wire        i_clock,
  input  wire        i_rst,
  input  wire [9:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  input  wire        i_slow_clock,
  input  wire        i_timer_io_pin,
  output wire        o_timer_io_pin,
  output wire        o_timer_io_oe_n,
  output wire        o_irq_one,
  output wire        o_irq_two
);

  // ****************************************************
  // functions
  // ****************************************************

  // counter tick from a clock select code
  function sel_tick;
    input [2:0] sel;
    input       ptick;
    input       stick;
    begin
      case (sel)
        `MTU_CSEL_PRESCALED: sel_tick = ptick;
        `MTU_CSEL_SLOW:      sel_tick = stick;
        default:             sel_tick = 1'b0;
      endcase
    end
  endfunction

  // write strobe for one register index
  function reg_hit;
    input [7:0] idx;
    input [7:0] want;
    begin
      reg_hit = (idx == want);
    end
  endfunction

  // ****************************************************
  // declarations
  // ****************************************************
  reg  [31:0]      rdata_r;
  reg              ack_r;
  reg  [PS_W-1:0]  prescale_divisor_r;
  reg  [PS_W-1:0]  prescale_value_r;
  reg  [2:0]       first_clock_select_r;
  reg  [2:0]       second_clock_select_r;
  reg  [1:0]       mode_select_field_r;
  reg              pin_edge_polarity_r;
  reg              pin_function_enable_r;
  reg              pin_initial_level_r;
  reg  [3:0]       src_enable_r;
  reg  [3:0]       src_pending_r;
  reg  [3:0]       src_pending_nxt;
  reg  [CNT_W-1:0] first_counter_r;
  reg  [CNT_W-1:0] second_counter_r;
  reg  [CNT_W-1:0] first_reload_capture_r;
  reg  [CNT_W-1:0] second_reload_r;
  reg              use_second_r;
  reg              pin_out_r;
  reg              slow_meta_r;
  reg              slow_sync_r;
  reg              slow_prev_r;
  reg              pin_meta_r;
  reg              pin_sync_r;
  reg              pin_prev_r;
  reg              irq_one_r;
  reg              irq_two_r;
  reg  [31:0]      rdata_nxt;

  wire [7:0]       idx;
  wire             access;
  wire             wr_en;
  wire             ptick;
  wire             stick;
  wire             tick1;
  wire             tick2;
  wire             uf1;
  wire             uf2;
  wire             mode_pwm;
  wire             mode_cap;
  wire             mode_dual;
  wire             cap_edge;
  wire             pin_drive;
  wire             toggle;
  wire             rise_toggle;

  // ****************************************************
  // avalon slave handshake
  // ****************************************************

  // one wait state, then the access completes
  assign idx               = i_avs_address[9:2];
  assign access            = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = access & ~ack_r;
  assign wr_en             = i_avs_write & ack_r;
  assign o_avs_readdata    = rdata_r;

  // ack pulses one cycle after a request shows
  always @(posedge i_clock) begin
    if (i_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access & ~ack_r;
    end
  end

  // read mux, unmapped indices read zero
  always @* begin
    rdata_nxt = `MTU_WORD_ZERO;
    case (idx)
      `MTU_IDX_FIRST_COUNTER:  rdata_nxt[CNT_W-1:0] = first_counter_r;
      `MTU_IDX_FIRST_RELOAD:   rdata_nxt[CNT_W-1:0] = first_reload_capture_r;
      `MTU_IDX_SECOND_RELOAD:  rdata_nxt[CNT_W-1:0] = second_reload_r;
      `MTU_IDX_SECOND_COUNTER: rdata_nxt[CNT_W-1:0] = second_counter_r;
      `MTU_IDX_PRESCALE:       rdata_nxt[PS_W-1:0]  = prescale_divisor_r;
      `MTU_IDX_CLOCK_CTRL: begin
        rdata_nxt[`MTU_CLK1_MSB:`MTU_CLK1_LSB] = first_clock_select_r;
        rdata_nxt[`MTU_CLK2_MSB:`MTU_CLK2_LSB] = second_clock_select_r;
      end
      `MTU_IDX_MODE_CTRL: begin
        rdata_nxt[`MTU_MODE_MSB:`MTU_MODE_LSB] = mode_select_field_r;
        rdata_nxt[`MTU_EDGE_BIT]               = pin_edge_polarity_r;
        rdata_nxt[`MTU_PINEN_BIT]              = pin_function_enable_r;
        rdata_nxt[`MTU_INIT_BIT]               = pin_initial_level_r;
      end
      `MTU_IDX_INT_CTRL: begin
        rdata_nxt[`MTU_PEND_MSB:`MTU_PEND_LSB] = src_pending_r;
        rdata_nxt[`MTU_IEN_MSB:`MTU_IEN_LSB]   = src_enable_r;
      end
      default: rdata_nxt = `MTU_WORD_ZERO;
    endcase
  end

  // read data captured as the ack rises
  always @(posedge i_clock) begin
    if (i_rst) begin
      rdata_r <= `MTU_WORD_ZERO;
    end else if (i_avs_read & ~ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************
  // control registers
  // ****************************************************

  always @(posedge i_clock) begin
    if (i_rst) begin
      prescale_divisor_r    <= `MTU_PS_ZERO;
      first_clock_select_r  <= `MTU_CSEL_STOP;
      second_clock_select_r <= `MTU_CSEL_STOP;
      mode_select_field_r   <= `MTU_MODE_PWM;
      pin_edge_polarity_r   <= 1'b0;
      pin_function_enable_r <= 1'b0;
      pin_initial_level_r   <= 1'b0;
      src_enable_r          <= `MTU_NIB_ZERO;
    end else if (wr_en) begin
      if (reg_hit(idx, `MTU_IDX_PRESCALE)) begin
        prescale_divisor_r <= i_avs_writedata[PS_W-1:0];
      end
      if (reg_hit(idx, `MTU_IDX_CLOCK_CTRL)) begin
        first_clock_select_r  <=
          i_avs_writedata[`MTU_CLK1_MSB:`MTU_CLK1_LSB];
        second_clock_select_r <=
          i_avs_writedata[`MTU_CLK2_MSB:`MTU_CLK2_LSB];
      end
      if (reg_hit(idx, `MTU_IDX_MODE_CTRL)) begin
        mode_select_field_r   <=
          i_avs_writedata[`MTU_MODE_MSB:`MTU_MODE_LSB];
        pin_edge_polarity_r   <= i_avs_writedata[`MTU_EDGE_BIT];
        pin_function_enable_r <= i_avs_writedata[`MTU_PINEN_BIT];
        pin_initial_level_r   <= i_avs_writedata[`MTU_INIT_BIT];
      end
      if (reg_hit(idx, `MTU_IDX_INT_CTRL)) begin
        src_enable_r <= i_avs_writedata[`MTU_IEN_MSB:`MTU_IEN_LSB];
      end
    end
  end

  // ****************************************************
  // prescaler and slow clock synchronizer
  // ****************************************************

  assign ptick = (prescale_value_r == `MTU_PS_ZERO);

  always @(posedge i_clock) begin
    if (i_rst) begin
      prescale_value_r <= `MTU_PS_ZERO;
    end else if (ptick) begin
      prescale_value_r <= prescale_divisor_r;
    end else begin
      prescale_value_r <= prescale_value_r - 1'b1;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      slow_meta_r <= 1'b0;
      slow_sync_r <= 1'b0;
      slow_prev_r <= 1'b0;
    end else begin
      slow_meta_r <= i_slow_clock;
      slow_sync_r <= slow_meta_r;
      slow_prev_r <= slow_sync_r;
    end
  end
  assign stick = slow_sync_r & ~slow_prev_r;

  always @(posedge i_clock) begin
    if (i_rst) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= i_timer_io_pin;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // ****************************************************
  // mode decode and events
  // ****************************************************

  assign mode_pwm  = (mode_select_field_r == `MTU_MODE_PWM);
  assign mode_cap  = (mode_select_field_r == `MTU_MODE_CAPTURE);
  assign mode_dual = (mode_select_field_r == `MTU_MODE_DUAL);

  assign tick1 = sel_tick(first_clock_select_r, ptick, stick);
  assign tick2 = sel_tick(second_clock_select_r, ptick, stick);
  assign uf1   = tick1 & (first_counter_r == `MTU_CNT_ZERO);
  assign uf2   = tick2 & (second_counter_r == `MTU_CNT_ZERO);

  assign cap_edge = mode_cap & (pin_edge_polarity_r ?
                    (pin_sync_r & ~pin_prev_r) :
                    (~pin_sync_r & pin_prev_r));

  assign pin_drive   = pin_function_enable_r & ~mode_cap;
  assign toggle      = pin_drive & uf1 & (mode_pwm | mode_dual);
  assign rise_toggle = toggle & mode_dual & ~pin_out_r;

  // ****************************************************
  // first counter
  // ****************************************************

  // all state only moves on the system clock
  always @(posedge i_clock) begin
    if (i_rst) begin
      first_counter_r <= `MTU_CNT_ZERO;
      use_second_r    <= 1'b0;
    end else begin
      if (wr_en & reg_hit(idx, `MTU_IDX_FIRST_COUNTER)) begin
        first_counter_r <= i_avs_writedata[CNT_W-1:0];
      end else if (cap_edge & pin_function_enable_r) begin
        first_counter_r <= `MTU_CNT_PRESET;
      end else if (tick1) begin
        if (uf1 & mode_pwm) begin
          first_counter_r <= use_second_r ? second_reload_r :
                             first_reload_capture_r;
        end else if (uf1 & mode_dual) begin
          first_counter_r <= first_reload_capture_r;
        end else begin
          first_counter_r <= first_counter_r - 1'b1;
        end
      end
      if (~mode_pwm |
          (first_clock_select_r == `MTU_CSEL_STOP)) begin
        use_second_r <= 1'b0;
      end else if (uf1) begin
        use_second_r <= ~use_second_r;
      end
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      first_reload_capture_r <= `MTU_CNT_ZERO;
    end else if (cap_edge) begin
      first_reload_capture_r <= first_counter_r;
    end else if (wr_en & reg_hit(idx, `MTU_IDX_FIRST_RELOAD)) begin
      first_reload_capture_r <= i_avs_writedata[CNT_W-1:0];
    end
  end

  // ****************************************************
  // second counter
  // ****************************************************

  always @(posedge i_clock) begin
    if (i_rst) begin
      second_counter_r <= `MTU_CNT_ZERO;
      second_reload_r  <= `MTU_CNT_ZERO;
    end else begin
      if (wr_en & reg_hit(idx, `MTU_IDX_SECOND_RELOAD)) begin
        second_reload_r <= i_avs_writedata[CNT_W-1:0];
      end
      if (wr_en & reg_hit(idx, `MTU_IDX_SECOND_COUNTER)) begin
        second_counter_r <= i_avs_writedata[CNT_W-1:0];
      end else if (uf2) begin
        second_counter_r <= second_reload_r;
      end else if (tick2) begin
        second_counter_r <= second_counter_r - 1'b1;
      end
    end
  end

  // ****************************************************
  // timer pin output
  // ****************************************************

  always @(posedge i_clock) begin
    if (i_rst) begin
      pin_out_r <= 1'b0;
    end else if (first_clock_select_r == `MTU_CSEL_STOP) begin
      pin_out_r <= pin_initial_level_r;
    end else if (toggle) begin
      pin_out_r <= ~pin_out_r;
    end
  end

  assign o_timer_io_pin  = pin_out_r;
  assign o_timer_io_oe_n = ~pin_drive;

  // ****************************************************
  // pending flags and interrupts
  // ****************************************************

  // pending set per mode, set beats clear
  always @* begin
    src_pending_nxt = src_pending_r;
    if (wr_en & reg_hit(idx, `MTU_IDX_INT_CLEAR)) begin
      src_pending_nxt = src_pending_r &
        ~i_avs_writedata[`MTU_PEND_MSB:`MTU_PEND_LSB];
    end
    if (mode_pwm & uf1 & ~use_second_r) begin
      src_pending_nxt[`MTU_SRC_A] = 1'b1;
    end
    if (mode_pwm & uf1 & use_second_r) begin
      src_pending_nxt[`MTU_SRC_B] = 1'b1;
    end
    if (cap_edge) begin
      src_pending_nxt[`MTU_SRC_A] = 1'b1;
    end
    if (mode_cap & uf1) begin
      src_pending_nxt[`MTU_SRC_C] = 1'b1;
    end
    if (rise_toggle) begin
      src_pending_nxt[`MTU_SRC_C] = 1'b1;
    end
    if (uf2) begin
      src_pending_nxt[`MTU_SRC_D] = 1'b1;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      src_pending_r <= `MTU_NIB_ZERO;
    end else begin
      src_pending_r <= src_pending_nxt;
    end
  end

  // group a, b, c onto irq one
  always @(posedge i_clock) begin
    if (i_rst) begin
      irq_one_r <= 1'b0;
      irq_two_r <= 1'b0;
    end else begin
      irq_one_r <=
        (src_pending_r[`MTU_SRC_A] & src_enable_r[`MTU_SRC_A]) |
        (src_pending_r[`MTU_SRC_B] & src_enable_r[`MTU_SRC_B]) |
        (src_pending_r[`MTU_SRC_C] &
         (mode_dual ? src_enable_r[`MTU_SRC_A] :
                      src_enable_r[`MTU_SRC_C]));
      irq_two_r <= src_pending_r[`MTU_SRC_D] & src_enable_r[`MTU_SRC_D];
    end
  end

  assign o_irq_one = irq_one_r;
  assign o_irq_two = irq_two_r;

endmodule

// *** verif/mtu_pin_model.sv ***
`timescale 1ns/10ps
module mtu_pin_model (
  input  wire i_clock,
  input  wire i_level,
  input  wire i_dut_pin,
  input  wire i_dut_oe_n,
  output wire o_pin
);
  reg level_r = 1'b0;
  // level held whole cycles
  // source level changes only at clock edges
  always @(posedge i_clock) begin
    level_r <= i_level;
  end
  // wire follows the design while it drives
  assign o_pin = i_dut_oe_n ? level_r : i_dut_pin;
endmodule

// *** verif/mtu_timer_chk.sv ***
`timescale 1ns/10ps
`include "mtu_defs.vh"
module mtu_timer_chk (
  input wire        i_clock,
  input wire        i_rst,
  input wire [9:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire        i_slow_clock,
  input wire        i_timer_io_pin,
  input wire        o_timer_io_pin,
  input wire        o_timer_io_oe_n,
  input wire        o_irq_one,
  input wire        o_irq_two
);
  // ****************************************************
  // shadows of the control fields written by software
  // ****************************************************
  reg  [5:0] clk_sh_r;
  reg  [6:0] mode_sh_r;
  reg  [3:0] ien_sh_r;
  wire [7:0] idx     = i_avs_address[9:2];
  wire       wr_done = i_avs_write & ~o_avs_waitrequest;
  wire       rd_done = i_avs_read & ~o_avs_waitrequest;
  wire       zero_rd = (idx < `MTU_IDX_FIRST_COUNTER) |
                       (idx > `MTU_IDX_INT_CTRL) | idx[0];
  wire       run1    = (clk_sh_r[2:0] == `MTU_CSEL_PRESCALED) |
                       (clk_sh_r[2:0] == `MTU_CSEL_SLOW);
  wire       drive   = mode_sh_r[`MTU_PINEN_BIT] &
                       (mode_sh_r[1:0] != `MTU_MODE_CAPTURE);

  // follow completed writes to the control registers
  always @(posedge i_clock) begin
    if (i_rst) begin
      clk_sh_r  <= 6'h00;
      mode_sh_r <= 7'h00;
      ien_sh_r  <= 4'h0;
    end else if (wr_done) begin
      case (idx)
        `MTU_IDX_CLOCK_CTRL: clk_sh_r <= i_avs_writedata[5:0];
        `MTU_IDX_MODE_CTRL:  mode_sh_r <= i_avs_writedata[6:0];
        `MTU_IDX_INT_CTRL:   ien_sh_r <= i_avs_writedata[7:4];
        default: ;
      endcase
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_req_rise;
    $rose(i_avs_read) || $rose(i_avs_write);
  endsequence
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence

  a_wait_state: assert property (s_req_rise |-> s_one_wait)
    else $error("bus access not one wait state");
  a_reset_quiet: assert property ($fell(i_rst) |->
    !o_irq_one && !o_irq_two && o_timer_io_oe_n && !o_timer_io_pin)
    else $error("outputs active after reset");
  a_oe_follow: assert property (o_timer_io_oe_n == !drive)
    else $error("pin enable wrong for mode");
  a_pin_idle: assert property (!run1 && $past(!run1) &&
    $stable(mode_sh_r[6]) |-> o_timer_io_pin == mode_sh_r[6])
    else $error("pin not at initial level");
  a_pin_toggle: assert property (run1 && $changed(o_timer_io_pin) |->
    drive && (mode_sh_r[1:0] != 2'b11))
    else $error("pin toggled while toggling off");
  a_irq_one_off: assert property (ien_sh_r[2:0] == 3'h0 &&
    $past(ien_sh_r[2:0]) == 3'h0 |-> !o_irq_one)
    else $error("irq one without enable");
  a_irq_two_off: assert property (!ien_sh_r[3] && $past(!ien_sh_r[3]) |->
    !o_irq_two)
    else $error("irq two without enable");
  a_unmapped_zero: assert property (rd_done && zero_rd |->
    o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (rd_done |->
    o_avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule

bind mtu_timer mtu_timer_chk mtu_timer_chk_inst (
  .i_clock(i_clock), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_slow_clock(i_slow_clock),
  .i_timer_io_pin(i_timer_io_pin), .o_timer_io_pin(o_timer_io_pin),
  .o_timer_io_oe_n(o_timer_io_oe_n), .o_irq_one(o_irq_one),
  .o_irq_two(o_irq_two));

// *** verif/mtu_timer_test.sv ***
`timescale 1ns/10ps
`include "mtu_defs.vh"
module mtu_timer_test;
  // ****************************************************
  // stimulus, partner and design
  // ****************************************************
  reg         i_clock       = 1'b0;
  reg         i_rst         = 1'b1;
  reg  [9:0]  avs_address   = 10'h000;
  reg         avs_read      = 1'b0;
  reg         avs_write     = 1'b0;
  reg  [31:0] avs_writedata = 32'h0000_0000;
  reg         slow_clock    = 1'b0;
  reg         pin_level     = 1'b0;
  reg  [31:0] seed          = 32'h0000_5bdf;
  reg  [31:0] q;
  reg  [7:0]  ix;
  wire [31:0] avs_readdata;
  wire        waitreq;
  wire        pin_wire;
  wire        o_pin;
  wire        oe_n;
  wire        irq_one;
  wire        irq_two;
  integer     miscompares   = 0;
  integer     n_compared    = 0;
  integer     i;
  integer     c;

  // system clock and an unrelated slow clock of eight cycles
  always #5 i_clock = ~i_clock;
  always #40 slow_clock = ~slow_clock;

  mtu_timer mtu_timer_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(waitreq), .i_slow_clock(slow_clock),
    .i_timer_io_pin(pin_wire), .o_timer_io_pin(o_pin),
    .o_timer_io_oe_n(oe_n), .o_irq_one(irq_one), .o_irq_two(irq_two));
  mtu_pin_model mtu_pin_model_inst (
    .i_clock(i_clock), .i_level(pin_level), .i_dut_pin(o_pin),
    .i_dut_oe_n(oe_n), .o_pin(pin_wire));

  function automatic [31:0] nr();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    nr = seed;
  endfunction

  // bits that read back as written in each register; interrupt clear and unmapped 52 get none, clock control gets none as it is only written zero
  function automatic [31:0] msk(input [7:0] idx);
    case (idx)
      `MTU_IDX_PRESCALE:  msk = 32'h0000_001F;
      `MTU_IDX_MODE_CTRL: msk = 32'h0000_0057;
      `MTU_IDX_INT_CTRL:  msk = 32'h0000_00F0;
      8'h40, 8'h42, 8'h44, 8'h46: msk = 32'h0000_FFFF;
      default: msk = 32'h0000_0000;
    endcase
  endfunction

  task complete_run;
    begin
      if (miscompares == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // one avalon access, held until waitrequest is low
  task bus(input w, input [7:0] idx, input [31:0] d);
    integer n;
    begin
      @(posedge i_clock);
      avs_address <= {idx, 2'b00};
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      n = 0;
      @(posedge i_clock);
      while (waitreq !== 1'b0 && n < 64) begin
        @(posedge i_clock);
        n = n + 1;
      end
      if (n >= 64) begin
        miscompares = miscompares + 1;
        complete_run;
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask

  task wr(input [7:0] idx, input [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task rd(input [7:0] idx);
    bus(1'b0, idx, 32'h0000_0000);
  endtask

  // cycles until the pin changes
  task gap;
    reg pv;
    begin
      c = 0;
      pv = o_pin;
      do begin
        @(negedge i_clock);
        c = c + 1;
      end while (o_pin === pv && c < 3000);
    end
  endtask

  task zero_regs;
    for (ix = 8'h40; ix <= 8'h52; ix = ix + 8'h02) begin
      rd(ix);
      check(q, 32'h0000_0000);
    end
  endtask

  // toggling run with random reloads and divisor
  task run_pin(input [1:0] mode, input [2:0] csel);
    reg [15:0] ra;
    reg [15:0] rb;
    reg [4:0]  d;
    integer    per;
    begin
      q = nr();
      ra = {12'h000, q[3:0]} + 16'h0001;
      rb = ra + {12'h000, q[7:4]} + 16'h0001;
      d = {3'b000, q[9:8]};
      per = (csel == `MTU_CSEL_SLOW) ? 8 : d + 1;
      wr(`MTU_IDX_CLOCK_CTRL, 32'h0000_0000);
      wr(`MTU_IDX_PRESCALE, {27'h000_0000, d});
      wr(`MTU_IDX_FIRST_RELOAD, {16'h0000, ra});
      wr(`MTU_IDX_SECOND_RELOAD, {16'h0000, rb});
      wr(`MTU_IDX_FIRST_COUNTER, 32'h0000_0000);
      wr(`MTU_IDX_SECOND_COUNTER, 32'h0000_0000);
      wr(`MTU_IDX_MODE_CTRL, {28'h000_0001, 2'b00, mode});
      wr(`MTU_IDX_INT_CLEAR, 32'h0000_000F);
      wr(`MTU_IDX_INT_CTRL, 32'h0000_0090);
      wr(`MTU_IDX_CLOCK_CTRL, {26'h000_0000, `MTU_CSEL_PRESCALED, csel});
      gap;
      check(o_pin, 1'b1);
      gap;
      check(c, (ra + 1) * per);
      gap;
      check(c, ((mode == `MTU_MODE_PWM ? rb : ra) + 1) * per);
      rd(`MTU_IDX_INT_CTRL);
      if (mode == `MTU_MODE_PWM)
        check(q, 32'h0000_009B);
      else
        check(q & 32'h0000_00FE, 32'h0000_009C);
      check(irq_one, 1'b1);
      check(irq_two, 1'b1);
      wr(`MTU_IDX_CLOCK_CTRL, 32'h0000_0000);
      wr(`MTU_IDX_INT_CLEAR, 32'h0000_000F);
      rd(`MTU_IDX_INT_CTRL);
      check(q, 32'h0000_0090);
      check(irq_one | irq_two, 1'b0);
      wr(`MTU_IDX_INT_CTRL, 32'h0000_0000);
    end
  endtask

  // two active edges n cycles apart, preset on capture
  task cap(input pol);
    integer n;
    begin
      q = nr();
      n = q[4:0] + 20;
      wr(`MTU_IDX_PRESCALE, 32'h0000_0000);
      wr(`MTU_IDX_FIRST_COUNTER, 32'h0000_FFFF);
      wr(`MTU_IDX_MODE_CTRL, {27'h000_0000, 2'b10, pol, 2'b01});
      wr(`MTU_IDX_INT_CLEAR, 32'h0000_000F);
      wr(`MTU_IDX_INT_CTRL, 32'h0000_0010);
      pin_level <= ~pol;
      wr(`MTU_IDX_CLOCK_CTRL, {29'h0000_0000, `MTU_CSEL_PRESCALED});
      repeat (8) @(posedge i_clock);
      pin_level <= pol;
      repeat (4) @(posedge i_clock);
      pin_level <= ~pol;
      repeat (n - 4) @(posedge i_clock);
      pin_level <= pol;
      repeat (8) @(posedge i_clock);
      rd(`MTU_IDX_FIRST_RELOAD);
      check(q, 32'h0000_FFFF - n + 1);
      rd(`MTU_IDX_INT_CTRL);
      check(q, 32'h0000_0011);
      check(irq_one, 1'b1);
      wr(`MTU_IDX_CLOCK_CTRL, 32'h0000_0000);
      wr(`MTU_IDX_INT_CLEAR, 32'h0000_000F);
      wr(`MTU_IDX_INT_CTRL, 32'h0000_0000);
    end
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    zero_regs;
    for (ix = 8'h40; ix <= 8'h52; ix = ix + 8'h02) begin
      q = (ix == `MTU_IDX_CLOCK_CTRL) ? 32'h0000_0000 : nr();
      c = q & msk(ix);
      wr(ix, q);
      rd(ix);
      check(q, c);
    end
    // slow clock used with the first counter only
    for (i = 0; i < 4; i = i + 1)
      run_pin(i[0] ? `MTU_MODE_DUAL : `MTU_MODE_PWM,
              i[1] ? `MTU_CSEL_SLOW : `MTU_CSEL_PRESCALED);
    cap(1'b1);
    cap(1'b0);
    wr(`MTU_IDX_PRESCALE, 32'h0000_001F);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    zero_regs;
    complete_run;
  end

  // watchdog against a hang
  initial begin
    #400_000;
    miscompares = miscompares + 1;
    complete_run;
  end
endmodule
